// File: logic/accel_activity_core.sv
// Notes on behaviour
// - five ODRs 320..5120 Hz, reset 320.
// - bandwidth selectable, resets to 160 Hz.
// - bandwidth clamped to half the ODR.
// - one-pole IIR high-pass, two-bit corner code.
// - high-pass corner scales with ODR.
// - high-pass and low-pass may run together.
// - slow settle: first sample after 463 ms.
// - fast settle: first sample within 1 ms.
// - reference captured on the fourth sample, three periods after the first.
// - spurious events possible while filter settles.
// - selectable low-noise option output.
// - events set flags except in wake, optionally raise interrupts.
// - awake bit shows moving or stationary.
// - detection in measure and wake; wake no interrupt.
// - 8 Hz averaging filter, bypassable.
// - any enabled axis over threshold long enough.
// - per-axis thresholds, one shared activity timer.
// - events change mode, interrupt, drive motion switch.
// - timer tick 8.25 ms, 4.125 ms at 5120.
// - referenced mode compares difference to reference.
// - standby clears interrupts and blocks new ones.
//
// Implementation choices: the register offsets and the plain strobed port.
module accel_activity_core import accel_pkg::*; #(
  parameter int ODR_DIV = ODR_DIV_CYC,
  parameter int SETTLE_SLOW = SETTLE_SLOW_CYC,
  parameter int SETTLE_FAST = SETTLE_FAST_CYC,
  parameter int ACT_TICK = ACT_TICK_CYC,
  parameter int INACT_TICK = INACT_TICK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] acc_x_in,
  input wire logic [DATA_W-1:0] acc_y_in,
  input wire logic [DATA_W-1:0] acc_z_in,
  output logic [15:0] rdata_out,
  output logic [2:0] odr_sel_out,
  output logic [2:0] bw_sel_out,
  output logic low_noise_out,
  output logic data_ready_out,
  output logic act_int_out,
  output logic inact_int_out,
  output logic motion_out
);
  typedef struct packed {
    run_state_t state;
    logic [1:0] mode_cmd;
    logic settle_fast;
    logic low_noise;
    logic hp_en;
    logic lp_en;
    logic [1:0] hp_code;
    logic [2:0] odr;
    logic [2:0] bw;
    logic [2:0] bw_applied;
    logic [2:0] axis_en;
    logic activity_referenced_select;
    logic act_ie;
    logic inact_ie;
    logic [7:0] act_time;
    logic [15:0] inact_time;
    logic [2:0][DATA_W-1:0] act_thr;
    logic [2:0][DATA_W-1:0] inact_thr;
    logic [2:0][DATA_W-1:0] data;
    logic ev_act;
    logic ev_inact;
    logic awake;
    logic data_rdy;
    logic int_act;
    logic int_inact;
    logic [CNT_W-1:0] div_cnt;
    logic [CNT_W-1:0] settle_cnt;
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] itick_cnt;
    logic [7:0] act_cnt;
    logic [15:0] inact_cnt;
    logic act_hold;
    logic inact_hold;
    logic [2:0] odr_n;
    logic ref_done;
    logic ref_cap;
    logic sample_tick;
    logic pub;
    logic clear;
    logic [15:0] rdata;
  } core_t;

  core_t st;
  core_t next_st;
  logic [2:0][DATA_W-1:0] acc_in;
  logic [2:0][DATA_W-1:0] ax_data;
  logic [2:0] ax_over;
  logic [2:0] ax_under;

  assign acc_in = {acc_z_in, acc_y_in, acc_x_in};

  // ----------------------------------------------------------------
  // Per-axis filter and comparator paths
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_axis
    axis_path u_axis (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_in(st.sample_tick),
      .clear_in(st.clear),
      .ref_cap_in(st.ref_cap),
      .ref_en_in(st.activity_referenced_select),
      .hp_en_in(st.hp_en),
      .lp_en_in(st.lp_en),
      .hp_code_in(st.hp_code),
      .odr_in(st.odr),
      .sample_in(acc_in[i]),
      .act_thr_in(st.act_thr[i]),
      .inact_thr_in(st.inact_thr[i]),
      .data_out(ax_data[i]),
      .over_out(ax_over[i]),
      .under_out(ax_under[i])
    );
  end

  // ----------------------------------------------------------------
  // Control, timing and register access
  // ----------------------------------------------------------------
  always_comb begin
    logic [CNT_W-1:0] div_lim;
    logic [CNT_W-1:0] settle_lim;
    logic [CNT_W-1:0] tick_lim;
    logic act_any;
    logic inact_all;
    logic restart;
    div_lim = (CNT_W'(ODR_DIV) << (RATE_MAX - st.odr)) - CNT_W'(1);
    settle_lim = st.settle_fast ? CNT_W'(SETTLE_FAST) : CNT_W'(SETTLE_SLOW);
    tick_lim = (st.odr == RATE_MAX) ? CNT_W'(ACT_TICK / 2) : CNT_W'(ACT_TICK);
    act_any = |(ax_over & st.axis_en);
    inact_all = (&(ax_under | ~st.axis_en)) && (|st.axis_en);
    restart = 1'b0;
    next_st = st;
    next_st.data_rdy = 1'b0;
    next_st.ref_cap = 1'b0;
    next_st.clear = 1'b0;
    next_st.rdata = 16'h0000;
    next_st.sample_tick = 1'b0;
    next_st.pub = st.sample_tick;
    next_st.bw_applied = (st.bw > st.odr) ? st.odr : st.bw;
    if (rd_in) begin
      case (addr_in)
        REG_CTRL: next_st.rdata = {8'h00, st.hp_code, st.lp_en, st.hp_en, st.low_noise,
                                   st.settle_fast, st.mode_cmd};
        REG_RATE: next_st.rdata = {10'h000, st.bw, st.odr};
        REG_ACT_CFG: next_st.rdata = {10'h000, st.inact_ie, st.act_ie, st.activity_referenced_select, st.axis_en};
        REG_ACT_TIME: next_st.rdata = {8'h00, st.act_time};
        REG_INACT_TIME: next_st.rdata = st.inact_time;
        4'h5, 4'h6, 4'h7: next_st.rdata = {4'h0, st.act_thr[2'(addr_in - REG_ACT_THR)]};
        4'h8, 4'h9, 4'hA: next_st.rdata = {4'h0, st.inact_thr[2'(addr_in - REG_INACT_THR)]};
        REG_STATUS: next_st.rdata = {13'h0000, st.state == ST_MEASURE, st.awake};
        REG_EVENT: begin
          next_st.rdata = {14'h0000, st.ev_inact, st.ev_act};
          next_st.ev_act = 1'b0;
          next_st.ev_inact = 1'b0;
        end
        4'hD, 4'hE, 4'hF: next_st.rdata = {4'h0, st.data[2'(addr_in - REG_DATA)]};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    if (wr_in) begin
      case (addr_in)
        REG_CTRL: begin
          next_st.mode_cmd = wdata_in[1:0];
          next_st.settle_fast = wdata_in[CTRL_SETTLE_BIT];
          next_st.low_noise = wdata_in[CTRL_NOISE_BIT];
          next_st.hp_en = wdata_in[CTRL_HP_EN_BIT];
          next_st.lp_en = wdata_in[CTRL_LP_EN_BIT];
          next_st.hp_code = wdata_in[CTRL_HP_CODE_LSB +: 2];
        end
        REG_RATE: begin
          next_st.odr = (wdata_in[2:0] > RATE_MAX) ? RATE_MAX : wdata_in[2:0];
          next_st.bw = (wdata_in[RATE_BW_LSB +: 3] > RATE_MAX) ? RATE_MAX
                                                                : wdata_in[RATE_BW_LSB +: 3];
        end
        REG_ACT_CFG: begin
          next_st.axis_en = wdata_in[2:0];
          next_st.activity_referenced_select = wdata_in[CFG_REF_BIT];
          next_st.act_ie = wdata_in[CFG_ACT_IE_BIT];
          next_st.inact_ie = wdata_in[CFG_INACT_IE_BIT];
        end
        REG_ACT_TIME: next_st.act_time = wdata_in[7:0];
        REG_INACT_TIME: next_st.inact_time = wdata_in;
        4'h5, 4'h6, 4'h7: next_st.act_thr[2'(addr_in - REG_ACT_THR)] = wdata_in[DATA_W-1:0];
        4'h8, 4'h9, 4'hA: next_st.inact_thr[2'(addr_in - REG_INACT_THR)] = wdata_in[DATA_W-1:0];
        default: ;
      endcase
    end
    // Sample clock: divider restarts at zero so the first sample comes at once.
    if (st.state != ST_STANDBY) begin
      next_st.sample_tick = (st.div_cnt == '0);
      next_st.div_cnt = (st.div_cnt >= div_lim) ? '0 : st.div_cnt + CNT_W'(1);
    end
    if (st.pub && st.odr_n < REF_WAIT_SAMPLES) begin
      next_st.odr_n = st.odr_n + 3'h1;
      if (st.odr_n == REF_WAIT_SAMPLES - 3'h1 && st.activity_referenced_select && !st.ref_done) begin
        next_st.ref_cap = 1'b1;
        next_st.ref_done = 1'b1;
      end
    end
    // Detection runs during settling too, so early events are possible.
    if (st.state == ST_SETTLE || st.state == ST_MEASURE) begin
      if (!act_any) begin
        next_st.act_cnt = 8'h00;
        next_st.tick_cnt = '0;
        next_st.act_hold = 1'b0;
      end else if (!st.act_hold) begin
        if (st.act_cnt >= st.act_time) begin
          next_st.ev_act = 1'b1;
          next_st.awake = 1'b1;
          next_st.act_hold = 1'b1;
        end else if (st.tick_cnt >= tick_lim - CNT_W'(1)) begin
          next_st.tick_cnt = '0;
          next_st.act_cnt = st.act_cnt + 8'h01;
        end else begin
          next_st.tick_cnt = st.tick_cnt + CNT_W'(1);
        end
      end
      if (!inact_all) begin
        next_st.inact_cnt = 16'h0000;
        next_st.itick_cnt = '0;
        next_st.inact_hold = 1'b0;
      end else if (!st.inact_hold) begin
        if (st.inact_cnt >= st.inact_time) begin
          next_st.ev_inact = 1'b1;
          next_st.awake = 1'b0;
          next_st.inact_hold = 1'b1;
        end else if (st.itick_cnt >= CNT_W'(INACT_TICK - 1)) begin
          next_st.itick_cnt = '0;
          next_st.inact_cnt = st.inact_cnt + 16'h0001;
        end else begin
          next_st.itick_cnt = st.itick_cnt + CNT_W'(1);
        end
      end
    end
    case (st.state)
      ST_STANDBY: begin
        if (st.mode_cmd == MODE_MEASURE) begin
          next_st.state = ST_SETTLE;
          restart = 1'b1;
        end else if (st.mode_cmd == MODE_WAKE) begin
          next_st.state = ST_WAKE;
          restart = 1'b1;
        end
      end
      ST_SETTLE: begin
        next_st.settle_cnt = st.settle_cnt + CNT_W'(1);
        if (st.settle_cnt >= settle_lim - CNT_W'(1)) begin
          next_st.state = ST_MEASURE;
          next_st.data_rdy = 1'b1;
          next_st.data = ax_data;
        end
      end
      ST_MEASURE: begin
        if (st.pub) begin
          next_st.data_rdy = 1'b1;
          next_st.data = ax_data;
        end
      end
      ST_WAKE: begin
        if (st.pub) begin
          next_st.data = ax_data;
        end
        // Single-sample detection; activity brings the part to full measurement.
        if (act_any) begin
          next_st.awake = 1'b1;
          next_st.state = ST_MEASURE;
          next_st.mode_cmd = MODE_MEASURE;
        end else if (st.mode_cmd == MODE_MEASURE) begin
          next_st.state = ST_SETTLE;
          restart = 1'b1;
        end
      end
      default: next_st.state = ST_STANDBY;
    endcase
    if (st.state != ST_STANDBY && st.mode_cmd == MODE_STANDBY) begin
      next_st.state = ST_STANDBY;
    end else if ((st.state == ST_SETTLE || st.state == ST_MEASURE) && st.mode_cmd == MODE_WAKE) begin
      next_st.state = ST_WAKE;
    end
    if (restart) begin
      next_st.clear = 1'b1;
      next_st.div_cnt = '0;
      next_st.settle_cnt = '0;
      next_st.odr_n = 3'h0;
      next_st.ref_done = 1'b0;
    end
    if (next_st.state == ST_STANDBY) begin
      next_st.ev_act = 1'b0;
      next_st.ev_inact = 1'b0;
      next_st.awake = 1'b0;
      next_st.act_hold = 1'b0;
      next_st.inact_hold = 1'b0;
      next_st.act_cnt = 8'h00;
      next_st.inact_cnt = 16'h0000;
    end
    next_st.int_act = next_st.ev_act && st.act_ie && (next_st.state == ST_SETTLE ||
                      next_st.state == ST_MEASURE);
    next_st.int_inact = next_st.ev_inact && st.inact_ie && (next_st.state == ST_SETTLE ||
                        next_st.state == ST_MEASURE);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.odr <= RATE_ODR_RST;
      st.bw <= RATE_BW_RST;
      st.bw_applied <= RATE_BW_RST;
      st.lp_en <= LP_EN_RST;
      st.state <= ST_STANDBY;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign odr_sel_out = st.odr;
  assign bw_sel_out = st.bw_applied;
  assign low_noise_out = st.low_noise;
  assign data_ready_out = st.data_rdy;
  assign act_int_out = st.int_act;
  assign inact_int_out = st.int_inact;
  assign motion_out = st.awake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_standby_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    st.state == ST_STANDBY |-> !act_int_out && !inact_int_out && !st.ev_act)
    else $error("interrupt or event pending in standby");
  chk_wake_no_int: assert property (@(posedge clk_in) disable iff (rst_in)
    st.state == ST_WAKE |-> !act_int_out && !inact_int_out)
    else $error("interrupt raised in wake-up mode");
  chk_bw_clamp: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 1'b1 |-> bw_sel_out <= $past(st.odr) && bw_sel_out <= $past(st.bw))
    else $error("applied bandwidth above half the rate");
  chk_awake_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(st.ev_act) |-> motion_out)
    else $error("activity did not set awake");
  chk_act_int: assert property (@(posedge clk_in) disable iff (rst_in)
    st.ev_act && st.act_ie && st.state == ST_MEASURE && st.mode_cmd == MODE_MEASURE
      && !(rd_in && addr_in == REG_EVENT) |=> act_int_out)
    else $error("enabled activity event gave no interrupt");
  chk_ref_timing: assert property (@(posedge clk_in) disable iff (rst_in)
    st.ref_cap |-> st.odr_n == REF_WAIT_SAMPLES && $past(st.pub))
    else $error("reference captured before four samples");
  chk_fast_settle: assert property (@(posedge clk_in) disable iff (rst_in)
    st.state == ST_SETTLE && st.settle_fast |-> st.settle_cnt < CNT_W'(SETTLE_FAST))
    else $error("fast settle ran past its limit");
  chk_first_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(st.state) == ST_SETTLE && st.state == ST_MEASURE |-> data_ready_out)
    else $error("first sample not published on leaving settle");
  chk_timer_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    st.state == ST_MEASURE && !(|(ax_over & st.axis_en)) |=> st.act_cnt == 8'h00)
    else $error("activity timer kept counting below threshold");
endmodule : accel_activity_core

// File: logic/accel_pkg.sv
package accel_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100_000;
  localparam int ODR_FAST_HZ = 5120;
  localparam int ODR_DIV_CYC = CLK_KHZ * 1000 / ODR_FAST_HZ;
  localparam int SETTLE_SLOW_MS = 463;
  localparam int SETTLE_SLOW_CYC = SETTLE_SLOW_MS * CLK_KHZ;
  localparam int SETTLE_FAST_MS = 1;
  localparam int SETTLE_FAST_CYC = SETTLE_FAST_MS * CLK_KHZ - 1;
  localparam int ACT_TICK_US = 8250;
  localparam int ACT_TICK_CYC = ACT_TICK_US * CLK_KHZ / 1000;
  localparam int INACT_TICK_US = 32500;
  localparam int INACT_TICK_CYC = INACT_TICK_US * CLK_KHZ / 1000;
  localparam logic [2:0] REF_WAIT_SAMPLES = 3'h4;
  // ----------------------------------------------------------------
  // Widths and filter shifts
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int FRAC_W = 6;
  localparam int ACC_W = 22;
  localparam int CNT_W = 27;
  localparam int HP_SHIFT_BASE = 5;
  localparam int LP_SHIFT_BASE = 3;
  localparam logic [2:0] RATE_MAX = 3'h4;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RATE = 4'h1;
  localparam logic [3:0] REG_ACT_CFG = 4'h2;
  localparam logic [3:0] REG_ACT_TIME = 4'h3;
  localparam logic [3:0] REG_INACT_TIME = 4'h4;
  localparam logic [3:0] REG_ACT_THR = 4'h5;
  localparam logic [3:0] REG_INACT_THR = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hB;
  localparam logic [3:0] REG_EVENT = 4'hC;
  localparam logic [3:0] REG_DATA = 4'hD;
  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SETTLE_BIT = 2;
  localparam int CTRL_NOISE_BIT = 3;
  localparam int CTRL_HP_EN_BIT = 4;
  localparam int CTRL_LP_EN_BIT = 5;
  localparam int CTRL_HP_CODE_LSB = 6;
  localparam int RATE_BW_LSB = 3;
  localparam int CFG_REF_BIT = 3;
  localparam int CFG_ACT_IE_BIT = 4;
  localparam int CFG_INACT_IE_BIT = 5;
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_MEASURE = 2'h2;
  localparam logic [2:0] RATE_ODR_RST = 3'h0;
  localparam logic [2:0] RATE_BW_RST = 3'h0;
  localparam logic LP_EN_RST = 1'b1;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_SETTLE = 2'b01,
    ST_MEASURE = 2'b10,
    ST_WAKE = 2'b11
  } run_state_t;
endpackage : accel_pkg

// File: logic/axis_path.sv
module axis_path import accel_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic ref_cap_in,
  input wire logic ref_en_in,
  input wire logic hp_en_in,
  input wire logic lp_en_in,
  input wire logic [1:0] hp_code_in,
  input wire logic [2:0] odr_in,
  input wire logic [DATA_W-1:0] sample_in,
  input wire logic [DATA_W-1:0] act_thr_in,
  input wire logic [DATA_W-1:0] inact_thr_in,
  output logic [DATA_W-1:0] data_out,
  output logic over_out,
  output logic under_out
);
  typedef struct packed {
    logic [ACC_W-1:0] xprev;
    logic [ACC_W-1:0] hp;
    logic [ACC_W-1:0] lp;
    logic [ACC_W-1:0] ref_lvl;
    logic [DATA_W-1:0] data;
    logic over;
    logic under;
  } axis_t;

  axis_t st;
  axis_t next_st;

  always_comb begin
    logic signed [ACC_W-1:0] x;
    logic signed [ACC_W-1:0] hp;
    logic signed [ACC_W-1:0] lp;
    logic signed [ACC_W-1:0] hp_val;
    logic signed [ACC_W-1:0] src;
    logic signed [ACC_W-1:0] diff;
    logic signed [ACC_W-1:0] mag;
    x = ACC_W'($signed({sample_in, {FRAC_W{1'b0}}}));
    hp = $signed(st.hp);
    lp = $signed(st.lp);
    hp_val = hp_en_in ? hp : x;
    src = lp_en_in ? lp : hp_val;
    diff = ref_en_in ? src - $signed(st.ref_lvl) : src;
    mag = diff[ACC_W-1] ? -diff : diff;
    next_st = st;
    if (clear_in) begin
      next_st = '0;
    end else begin
      if (tick_in) begin
        next_st.xprev = x;
        // Shift grows with the code, so the corner falls; per-sample update tracks ODR.
        next_st.hp = hp - (hp >>> (HP_SHIFT_BASE + hp_code_in)) + (x - $signed(st.xprev));
        // Averaging corner near 8 Hz: one more shift per doubling of the rate.
        next_st.lp = lp + ((hp_val - lp) >>> (LP_SHIFT_BASE + odr_in));
      end
      if (ref_cap_in) begin
        next_st.ref_lvl = src;
      end
      next_st.data = hp_val[FRAC_W +: DATA_W];
      next_st.over = mag > $signed(ACC_W'({act_thr_in, {FRAC_W{1'b0}}}));
      next_st.under = mag < $signed(ACC_W'({inact_thr_in, {FRAC_W{1'b0}}}));
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.data;
  assign over_out = st.over;
  assign under_out = st.under;
endmodule : axis_path

// File: tb/host_model.sv
module host_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse of their last value, so nothing
  // can lean on stale address or data.
  initial begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rdata_in;
  endtask : rd_reg
endmodule : host_model

// File: tb/accel_filter_activity_detect_bench.sv
module accel_filter_activity_detect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import accel_pkg::*;
  localparam int SF = 50;
  localparam int SS = 400;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] ax = '0;
  logic [DATA_W-1:0] ay = '0;
  logic [DATA_W-1:0] az = '0;
  logic [2:0] odr_sel;
  logic [2:0] bw_sel;
  logic low_noise, dr, act_int, inact_int, motion;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'hf8fd_2171;
  logic [15:0] rv;
  int cyc;
  int o;
  int b;
  always #5 clk_in = ~clk_in;
  host_model host_model_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  accel_activity_core #(.ODR_DIV(20), .SETTLE_SLOW(SS), .SETTLE_FAST(SF), .ACT_TICK(16),
    .INACT_TICK(40)) accel_activity_core_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .acc_x_in(ax),
    .acc_y_in(ay), .acc_z_in(az), .rdata_out(rdata), .odr_sel_out(odr_sel),
    .bw_sel_out(bw_sel), .low_noise_out(low_noise), .data_ready_out(dr),
    .act_int_out(act_int), .inact_int_out(inact_int), .motion_out(motion));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wait_for(ref logic sig, input int lim, output int n);
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      n++;
    end
  endtask : wait_for
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check("odr_sel", 16'h0000, 16'(odr_sel));
    check("bw_sel", 16'h0000, 16'(bw_sel));
    host_model_i.rd_reg(REG_CTRL, rv);
    check("ctrl", 16'h0020, rv);
    host_model_i.rd_reg(REG_RATE, rv);
    check("rate", 16'h0000, rv);
    repeat (12) begin
      seed = xorshift(seed);
      o = int'(seed % 32'd5);
      b = int'((seed >> 8) % 32'd5);
      host_model_i.wr_reg(REG_RATE, 16'(o) | 16'(b << RATE_BW_LSB));
      repeat (2) @(posedge clk_in);
      check("odr_sel", 16'(o), 16'(odr_sel));
      check("bw_sel", 16'(b > o ? o : b), 16'(bw_sel));
    end
    host_model_i.wr_reg(REG_CTRL, 16'h0008);
    repeat (2) @(posedge clk_in);
    check("low_noise", 16'h0001, 16'(low_noise));
    // Configuration is only touched in standby.
    host_model_i.wr_reg(REG_CTRL, 16'h0000);
    host_model_i.wr_reg(REG_RATE, 16'h0003);
    host_model_i.wr_reg(REG_ACT_CFG, 16'h0017);
    host_model_i.wr_reg(REG_ACT_TIME, 16'h0002);
    host_model_i.wr_reg(REG_ACT_THR, 16'h07d0);
    host_model_i.wr_reg(REG_ACT_THR + 4'h1, 16'h07d0);
    host_model_i.wr_reg(REG_ACT_THR + 4'h2, 16'h000a);
    seed = xorshift(seed);
    ax <= 12'(seed % 32'd1900);
    ay <= ~12'(seed % 32'd1900);
    az <= 12'h005;
    host_model_i.wr_reg(REG_CTRL, 16'h0006);
    wait_for(dr, SF + 20, cyc);
    check("fast settle", 16'h0001, 16'(cyc inside {[SF - 2:SF + 5]}));
    repeat (200) @(posedge clk_in);
    check("act under", 16'h0000, 16'(act_int));
    az <= 12'hf38;
    wait_for(act_int, 300, cyc);
    check("act time", 16'h0001, 16'(cyc inside {[2 * 16:2 * 16 + 8]}));
    check("awake", 16'h0001, 16'(motion));
    host_model_i.rd_reg(REG_EVENT, rv);
    check("act flag", 16'h0001, rv & 16'h0001);
    host_model_i.wr_reg(REG_CTRL, 16'h0000);
    repeat (100) @(posedge clk_in);
    check("standby int", 16'h0000, 16'(act_int));
    check("standby awake", 16'h0000, 16'(motion));
    check("standby iint", 16'h0000, 16'(inact_int));
    host_model_i.wr_reg(REG_CTRL, 16'h0072);
    wait_for(dr, SS + 20, cyc);
    check("slow settle", 16'h0001, 16'(cyc inside {[SS - 2:SS + 5]}));
    // The high-pass path pulls the constant z input back towards zero.
    host_model_i.rd_reg(REG_DATA + 4'h2, rv);
    check("hp data", 16'h0001, 16'(rv > 16'h0f38));
    host_model_i.wr_reg(REG_CTRL, 16'h0000);
    host_model_i.wr_reg(REG_ACT_TIME, 16'h00c8);
    host_model_i.rd_reg(REG_EVENT, rv);
    host_model_i.wr_reg(REG_CTRL, 16'h0001);
    wait_for(motion, 1000, cyc);
    check("wake awake", 16'h0001, 16'(motion));
    check("wake int", 16'h0000, 16'(act_int));
    host_model_i.rd_reg(REG_EVENT, rv);
    check("wake flag", 16'h0000, rv & 16'h0001);
    // Only the captured reference can bring every axis under its inactivity threshold.
    host_model_i.wr_reg(REG_CTRL, 16'h0000);
    host_model_i.wr_reg(REG_ACT_CFG, 16'h002f);
    host_model_i.wr_reg(REG_INACT_TIME, 16'h0002);
    host_model_i.wr_reg(REG_INACT_THR, 16'h000a);
    host_model_i.wr_reg(REG_INACT_THR + 4'h1, 16'h000a);
    host_model_i.wr_reg(REG_INACT_THR + 4'h2, 16'h000a);
    host_model_i.wr_reg(REG_CTRL, 16'h0006);
    wait_for(inact_int, 400, cyc);
    check("ref inact", 16'h0001, 16'(cyc inside {[200:248]}));
    host_model_i.rd_reg(REG_EVENT, rv);
    check("inact flag", 16'h0002, rv);
    host_model_i.rd_reg(REG_STATUS, rv);
    check("status", 16'h0002, rv);
    host_model_i.rd_reg(REG_DATA, rv);
    check("data x", {4'h0, ax}, rv);
    end_of_test();
  end
  initial begin
    #200_000;
    error_cnt++;
    end_of_test();
  end
endmodule : accel_filter_activity_detect_bench
